// File: src/operand_type_datapath.sv
/*
 Operand-type datapath: byte, word and 32-bit operations, bit tests,
 signed overflow into the status flags, and the register-file word interface.
 Assumes the decoder presents one operation per valid cycle with operands
 already fetched; long operations take one cycle here (no iteration).
*/
// Function
// - Byte arithmetic and compares wrap modulo 256 over values 0 to 255.
// - Byte logic combines corresponding bits independently.
// - Word bit positions run 0 to 15 with 0 the least significant.
// - Word operands sit at even byte addresses.
// - A word keeps its low byte at the even address, high byte next; its address is the low byte.
// - Signed byte results outside -128..+127 set the overflow flags.
// - Signed byte results are the same bits as the unsigned byte result.
// - Signed byte operands may sit at any byte address.
// - Signed word results outside -32768..32767 set overflow; bits match unsigned.
// - Signed words follow the word alignment and low-byte-first rules.
// - Any register-file bit can be tested, addressed only as a position in a byte or word.
// - Unsigned 32-bit operands serve only shifts, divide dividend and multiply product.
// - Unsigned 32-bit operands live in the register file at addresses divisible by 4.
// - Signed 32-bit operands also serve normalize, beside shifts, divide and multiply.
// - Signed 32-bit operands live in the register file at addresses divisible by 4.
// - The first two register-file bytes always read as zero.
`timescale 1ns/1ps
`default_nettype none
module operand_type_datapath
   import optype_pkg::*;
(
   // Clock and reset.
   input  wire logic                             sys_clk,
   input  wire logic                             arst_n,
   // Operation request.
   input  wire logic                             op_valid,
   input  wire optype_pkg::opcode_t              opcode,
   input  wire optype_pkg::optype_t              otype,
   input  wire logic [optype_pkg::LONG_W-1:0]    opa,
   input  wire logic [optype_pkg::WORD_W-1:0]    opb,
   input  wire logic [optype_pkg::BITPOS_W-1:0]  bit_pos,
   input  wire logic [optype_pkg::ADDR_W-1:0]    op_addr,
   input  wire logic                             op_in_rf,
   // Register-file byte write path and word read address.
   input  wire logic                             rf_wr,
   input  wire logic [optype_pkg::RF_ADDR_W-1:0] rf_waddr,
   input  wire logic [optype_pkg::BYTE_W-1:0]    rf_wdata,
   input  wire logic [optype_pkg::RF_ADDR_W-1:0] rf_raddr,
   // Results.
   output logic                                  res_valid,
   output logic [optype_pkg::LONG_W-1:0]         result,
   output logic                                  flag_zero,
   output logic                                  flag_neg,
   output logic                                  flag_carry,
   output logic                                  flag_ovf,
   output logic                                  flag_ovf_sticky,
   output logic                                  bit_true,
   output logic                                  op_fault,
   output logic [optype_pkg::WORD_W-1:0]         rf_rdata
);
   logic [1:0] rst_sync;
   wire        rst_n = rst_sync[1];

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // Register file with the zero register hard-wired.
   logic [BYTE_W-1:0] rf_mem [RF_BYTES];

   always_ff @(posedge sys_clk) begin
      if (rf_wr && rf_waddr > ZERO_REG_LAST) begin
         rf_mem[rf_waddr] <= rf_wdata;
      end
   end

   // Word read: low byte at even address, high byte at the next odd one.
   wire [RF_ADDR_W-1:0] rd_lo   = {rf_raddr[RF_ADDR_W-1:1], 1'b0};
   wire [RF_ADDR_W-1:0] rd_hi   = {rf_raddr[RF_ADDR_W-1:1], 1'b1};
   wire                 rd_zero = rd_lo <= ZERO_REG_LAST;
   wire [WORD_W-1:0]    rd_word = rd_zero ? '0 : {rf_mem[rd_hi], rf_mem[rd_lo]};

   // Alignment checks.
   logic misaligned;

   operand_aligner u_align (
      .addr         (op_addr),
      .otype        (otype),
      .in_rf        (op_in_rf),
      .misaligned   (misaligned),
      .low_lane_odd ()
   );

   wire is_byte  = (otype == TYPE_BYTE) || (otype == TYPE_SHORT);
   wire is_long  = (otype == TYPE_DWORD) || (otype == TYPE_LONG);
   wire is_sub   = (opcode == OP_SUB) || (opcode == OP_CMP);

   // 32-bit types accept only these operations.
   wire long_ok  = (opcode == OP_SHL) || (opcode == OP_SHR) || (opcode == OP_DIV) ||
                   (opcode == OP_MUL) || (opcode == OP_NORM && otype == TYPE_LONG);
   wire op_bad   = is_long ? !long_ok :
                   (opcode == OP_DIV || opcode == OP_NORM);
   wire fault    = misaligned || op_bad;

   // Add and subtract at word width; bytes take the low lane.
   wire [WORD_W-1:0] a16   = opa[WORD_W-1:0];
   wire [WORD_W-1:0] b_inv = is_sub ? ~opb : opb;
   wire [WORD_W:0]   sum16 = {1'b0, a16} + {1'b0, b_inv} + {{WORD_W{1'b0}}, is_sub};
   wire [BYTE_W:0]   sum8  = {1'b0, a16[BYTE_W-1:0]} + {1'b0, b_inv[BYTE_W-1:0]}
                             + {{BYTE_W{1'b0}}, is_sub};

   // Signed overflow: operands of one sign giving the other sign.
   wire ovf8  = (a16[BYTE_W-1] == b_inv[BYTE_W-1]) &&
                (sum8[BYTE_W-1] != a16[BYTE_W-1]);
   wire ovf16 = (a16[WORD_W-1] == b_inv[WORD_W-1]) &&
                (sum16[WORD_W-1] != a16[WORD_W-1]);

   // Bitwise logic acts per position.
   wire [WORD_W-1:0] and_v = a16 & opb;
   wire [WORD_W-1:0] or_v  = a16 | opb;
   wire [WORD_W-1:0] xor_v = a16 ^ opb;

   // Bit test by position within the operand.
   wire [BITPOS_W-1:0] bpos    = is_byte ? {1'b0, bit_pos[BITPOS_W-2:0]} : bit_pos;
   wire                bit_val = a16[bpos];

   // Shifts over 32 bits, arithmetic right for signed long.
   wire [SHIFT_W-1:0] sh      = opb[SHIFT_W-1:0];
   wire [LONG_W-1:0]  shl_v   = opa << sh;
   wire [LONG_W-1:0]  shr_v   = (otype == TYPE_LONG) ? LONG_W'($signed(opa) >>> sh) : opa >> sh;

   // Multiply product and divide of 32 by 16 (quotient low, remainder high).
   wire [LONG_W-1:0] mul_v = {{WORD_W{1'b0}}, a16} * {{WORD_W{1'b0}}, opb};
   wire              div0  = (opb == '0);
   wire [LONG_W-1:0] quo   = div0 ? '1 : opa / {{WORD_W{1'b0}}, opb};
   wire [LONG_W-1:0] rem   = div0 ? opa : opa % {{WORD_W{1'b0}}, opb};
   wire [LONG_W-1:0] div_v = {rem[WORD_W-1:0], quo[WORD_W-1:0]};

   // Normalize: shift left until bit 31 is set; the shift count is not output.
   logic [SHIFT_W-1:0] norm_cnt;
   always_comb begin
      norm_cnt = '0;
      for (int i = 0; i < LONG_W; i++) begin
         if (opa[i]) begin
            norm_cnt = SHIFT_W'(LONG_W - 1 - i);
         end
      end
   end
   wire [LONG_W-1:0] norm_v = opa << norm_cnt;

   // Result selection.
   logic [LONG_W-1:0] next_result;
   logic              next_carry;
   logic              next_ovf;
   always_comb begin
      next_result = '0;
      next_carry  = 1'b0;
      next_ovf    = 1'b0;
      case (opcode)
         OP_ADD, OP_SUB, OP_CMP: begin
            if (is_byte) begin
               next_result = {{(LONG_W-BYTE_W){1'b0}}, sum8[BYTE_W-1:0]};
               next_carry  = sum8[BYTE_W];
               next_ovf    = (otype == TYPE_SHORT) && ovf8;
            end else begin
               next_result = {{WORD_W{1'b0}}, sum16[WORD_W-1:0]};
               next_carry  = sum16[WORD_W];
               next_ovf    = (otype == TYPE_INT) && ovf16;
            end
         end
         OP_AND:   next_result = {{WORD_W{1'b0}}, and_v};
         OP_OR:    next_result = {{WORD_W{1'b0}}, or_v};
         OP_XOR:   next_result = {{WORD_W{1'b0}}, xor_v};
         OP_BTEST: next_result = {{(LONG_W-1){1'b0}}, bit_val};
         OP_SHL:   next_result = shl_v;
         OP_SHR:   next_result = shr_v;
         OP_MUL:   next_result = mul_v;
         OP_DIV: begin
            next_result = div_v;
            next_ovf    = div0 || (quo[LONG_W-1:WORD_W] != '0);
         end
         OP_NORM:  next_result = norm_v;
         default:  next_result = '0;
      endcase
      if (is_byte && opcode != OP_BTEST) begin
         next_result = {{(LONG_W-BYTE_W){1'b0}}, next_result[BYTE_W-1:0]};
      end
   end

   wire [LONG_W-1:0] masked = fault ? '0 : next_result;
   wire              res_z  = is_byte ? (masked[BYTE_W-1:0] == '0) :
                              is_long ? (masked == '0) : (masked[WORD_W-1:0] == '0);
   wire              res_n  = is_byte ? masked[BYTE_W-1] :
                              is_long ? masked[LONG_W-1] : masked[WORD_W-1];
   wire              do_op  = op_valid && rst_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_valid       <= 1'b0;
         result          <= '0;
         flag_zero       <= 1'b0;
         flag_neg        <= 1'b0;
         flag_carry      <= 1'b0;
         flag_ovf        <= 1'b0;
         flag_ovf_sticky <= 1'b0;
         bit_true        <= 1'b0;
         op_fault        <= 1'b0;
         rf_rdata        <= RESULT_RESET;
      end else begin
         rf_rdata  <= rd_word;
         res_valid <= do_op;
         if (do_op) begin
            result     <= masked;
            op_fault   <= fault;
            flag_zero  <= res_z;
            flag_neg   <= res_n;
            flag_carry <= !fault && next_carry;
            flag_ovf   <= !fault && next_ovf;
            bit_true   <= !fault && (opcode == OP_BTEST) && bit_val;
            if (!fault && next_ovf) begin
               flag_ovf_sticky <= 1'b1;
            end
         end
      end
   end

   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Sign-extended difference, kept apart from the adder so the flag is judged independently.
   wire [WORD_W:0] chk_diff = {a16[WORD_W-1], a16} - {opb[WORD_W-1], opb};

   sequence byte_add_s;
      op_valid && opcode == OP_ADD && otype == TYPE_BYTE && !fault;
   endsequence

   byte_wrap_a: assert property (byte_add_s |=> result[BYTE_W-1:0] ==
      BYTE_W'($past(opa[BYTE_W-1:0]) + $past(opb[BYTE_W-1:0])))
      else $error("byte add did not wrap modulo 256");
   logic_and_a: assert property (op_valid && opcode == OP_AND && otype == TYPE_WORD
      && !fault |=> result[WORD_W-1:0] == ($past(opa[WORD_W-1:0]) & $past(opb)))
      else $error("bitwise and mismatch");
   bit_test_a: assert property (op_valid && opcode == OP_BTEST && otype == TYPE_WORD
      && !fault |=> bit_true == $past(opa[bit_pos]))
      else $error("bit test picked the wrong position");
   word_align_a: assert property (op_valid && otype == TYPE_WORD && op_addr[0]
      |=> op_fault && result == '0)
      else $error("odd word address accepted");
   short_ovf_a: assert property (op_valid && opcode == OP_ADD && otype == TYPE_SHORT
      && !fault && opa[7] == opb[7] && sum8[7] != opa[7] |=> flag_ovf && flag_ovf_sticky)
      else $error("short overflow not flagged");
   short_bits_a: assert property (op_valid && otype == TYPE_SHORT && opcode == OP_ADD
      && !fault |=> result[BYTE_W-1:0] ==
      BYTE_W'($past(opa[BYTE_W-1:0]) + $past(opb[BYTE_W-1:0])))
      else $error("short result differs from byte result");
   short_any_a: assert property (op_valid && otype == TYPE_SHORT && opcode == OP_ADD
      |=> !op_fault)
      else $error("short operand refused for its address");
   int_ovf_a: assert property (op_valid && opcode == OP_SUB && otype == TYPE_INT
      && !fault |=> flag_ovf == $past(chk_diff[WORD_W] != chk_diff[WORD_W-1]))
      else $error("integer overflow flag wrong");
   long_ops_a: assert property (op_valid && otype == TYPE_DWORD && opcode == OP_ADD
      |=> op_fault)
      else $error("unsupported double-word operation accepted");
   long_align_a: assert property (op_valid && otype == TYPE_LONG && op_addr[1:0] != 2'b00
      |=> op_fault)
      else $error("misaligned long accepted");
   zero_reg_a: assert property (rf_raddr <= ZERO_REG_LAST |=> rf_rdata == '0)
      else $error("zero register read nonzero");

   sequence int_add_s;
      op_valid && opcode == OP_ADD && otype == TYPE_INT && !fault;
   endsequence

   sequence long_norm_s;
      op_valid && opcode == OP_NORM && otype == TYPE_LONG && !fault;
   endsequence

   sequence fault_op_s;
      op_valid && fault;
   endsequence

   int_bits_a: assert property (int_add_s |=> result[WORD_W-1:0] ==
      WORD_W'($past(opa[WORD_W-1:0]) + $past(opb)))
      else $error("integer sum differs from word sum");
   int_align_a: assert property (op_valid && otype == TYPE_INT && op_addr[0]
      |=> op_fault)
      else $error("odd integer address accepted");
   dword_place_a: assert property (op_valid && otype == TYPE_DWORD
      && (op_addr[1:0] != 2'b00 || !op_in_rf) |=> op_fault)
      else $error("misplaced double word accepted");
   norm_dword_a: assert property (op_valid && opcode == OP_NORM && otype == TYPE_DWORD
      |=> op_fault)
      else $error("normalize accepted for unsigned long");
   long_norm_a: assert property (long_norm_s |=> result[LONG_W-1] == ($past(opa) != '0))
      else $error("normalize left the top bit clear");
   fault_quiet_a: assert property (fault_op_s |=> result == '0 && !flag_ovf
      && !flag_carry && !bit_true)
      else $error("refused operation left a result or flag");
   byte_bit_a: assert property (op_valid && opcode == OP_BTEST && otype == TYPE_BYTE
      && !fault |=> bit_true == $past(opa[{1'b0, bit_pos[BITPOS_W-2:0]}]))
      else $error("byte bit test picked the wrong position");
endmodule
`default_nettype wire

// File: src/optype_pkg.sv
/*
 Shared constants for the operand-type datapath: widths, operation codes,
 operand types, alignment masks and register file layout.
 Assumes a single clock domain and an asynchronous active-low chip reset.
*/
package optype_pkg;
   localparam int BYTE_W       = 8;
   localparam int WORD_W       = 16;
   localparam int LONG_W       = 32;
   localparam int ADDR_W       = 16;
   localparam int RF_ADDR_W    = 8;
   localparam int RF_BYTES     = 256;
   localparam int BITPOS_W     = 4;
   localparam int SHIFT_W      = 5;
   localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK = 16'h0001;
   localparam logic [ADDR_W-1:0] LONG_ALIGN_MASK = 16'h0003;
   localparam logic [RF_ADDR_W-1:0] ZERO_REG_LAST = 8'h01;
   localparam logic [WORD_W-1:0] RESULT_RESET  = 16'h0000;

   typedef enum logic [2:0] {
      TYPE_BYTE  = 3'h0,
      TYPE_SHORT = 3'h1,
      TYPE_WORD  = 3'h2,
      TYPE_INT   = 3'h3,
      TYPE_DWORD = 3'h4,
      TYPE_LONG  = 3'h5
   } optype_t;

   typedef enum logic [3:0] {
      OP_ADD   = 4'h0,
      OP_SUB   = 4'h1,
      OP_AND   = 4'h2,
      OP_OR    = 4'h3,
      OP_XOR   = 4'h4,
      OP_CMP   = 4'h5,
      OP_BTEST = 4'h6,
      OP_SHL   = 4'h7,
      OP_SHR   = 4'h8,
      OP_MUL   = 4'h9,
      OP_DIV   = 4'ha,
      OP_NORM  = 4'hb
   } opcode_t;
endpackage

// File: src/operand_aligner.sv
/*
 Alignment checker and byte-lane steering for operand addresses.
 Assumes the caller presents an address with its operand type each cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module operand_aligner
   import optype_pkg::*;
(
   // Request.
   input  wire logic [optype_pkg::ADDR_W-1:0] addr,
   input  wire optype_pkg::optype_t           otype,
   input  wire logic                          in_rf,
   // Result.
   output logic                               misaligned,
   output logic                               low_lane_odd
);
   wire word_type = (otype == TYPE_WORD) || (otype == TYPE_INT);
   wire long_type = (otype == TYPE_DWORD) || (otype == TYPE_LONG);
   wire word_bad  = word_type && ((addr & WORD_ALIGN_MASK) != '0);
   wire long_bad  = long_type &&
                    (((addr & LONG_ALIGN_MASK) != '0) || !in_rf);
   // Byte operands of either sign pass at any address.
   assign misaligned   = word_bad || long_bad;
   // The operand address names its low-order byte.
   assign low_lane_odd = addr[0];
endmodule
`default_nettype wire

// File: tb/decoder_model.sv
/*
 Behavioural decoder that issues one operation to the datapath.
 Assumes the bench raises go between edges and the datapath samples on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module decoder_model
   import optype_pkg::*;
(
   // Clock.
   input  wire logic                            sys_clk,
   // Request from the bench.
   input  wire logic                            go,
   input  wire optype_pkg::opcode_t             want_op,
   input  wire optype_pkg::optype_t             want_type,
   input  wire logic [optype_pkg::LONG_W-1:0]   arg_a,
   input  wire logic [optype_pkg::WORD_W-1:0]   arg_b,
   input  wire logic [optype_pkg::BITPOS_W-1:0] arg_bit,
   input  wire logic [optype_pkg::ADDR_W-1:0]   arg_addr,
   input  wire logic                            arg_rf,
   // Request to the datapath.
   output logic                                 op_valid,
   output optype_pkg::opcode_t                  opcode,
   output optype_pkg::optype_t                  otype,
   output logic [optype_pkg::LONG_W-1:0]        opa,
   output logic [optype_pkg::WORD_W-1:0]        opb,
   output logic [optype_pkg::BITPOS_W-1:0]      bit_pos,
   output logic [optype_pkg::ADDR_W-1:0]        op_addr,
   output logic                                 op_in_rf
);
   initial begin
      op_valid = 1'b0;
      opcode   = OP_ADD;
      otype    = TYPE_BYTE;
      opa      = 32'h0000_0000;
      opb      = 16'h0000;
      bit_pos  = 4'h0;
      op_addr  = 16'h0000;
      op_in_rf = 1'b0;
   end

   // Idle opa and opb are inverted each cycle, so a stale value returns on every second idle cycle.
   always @(negedge sys_clk) begin
      op_valid <= go;
      if (go) begin
         opcode   <= want_op;
         otype    <= want_type;
         opa      <= arg_a;
         opb      <= arg_b;
         bit_pos  <= arg_bit;
         op_addr  <= arg_addr;
         op_in_rf <= arg_rf;
      end else begin
         opa <= ~opa;
         opb <= ~opb;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
 Self-checking bench for the operand-type datapath.
 Assumes the decoder model issues operations and the bench drives the register file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import optype_pkg::*;
   logic sys_clk, arst_n, go, arg_rf, rf_wr;
   opcode_t want_op, opcode;
   optype_t want_type, otype;
   logic [31:0] arg_a, opa, result;
   logic [15:0] arg_b, opb, arg_addr, op_addr, rf_rdata;
   logic [3:0]  arg_bit, bit_pos;
   logic [7:0]  rf_waddr, rf_wdata, rf_raddr;
   logic op_valid, op_in_rf, res_valid, flag_zero, flag_neg, flag_carry, flag_ovf;
   logic flag_ovf_sticky, bit_true, op_fault;
   int num_errors = 0;
   int checks_done = 0;

   decoder_model partner_u (.sys_clk(sys_clk), .go(go), .want_op(want_op),
      .want_type(want_type), .arg_a(arg_a), .arg_b(arg_b), .arg_bit(arg_bit),
      .arg_addr(arg_addr), .arg_rf(arg_rf), .op_valid(op_valid), .opcode(opcode),
      .otype(otype), .opa(opa), .opb(opb), .bit_pos(bit_pos), .op_addr(op_addr),
      .op_in_rf(op_in_rf));

   operand_type_datapath dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid),
      .opcode(opcode), .otype(otype), .opa(opa), .opb(opb), .bit_pos(bit_pos),
      .op_addr(op_addr), .op_in_rf(op_in_rf), .rf_wr(rf_wr), .rf_waddr(rf_waddr),
      .rf_wdata(rf_wdata), .rf_raddr(rf_raddr), .res_valid(res_valid), .result(result),
      .flag_zero(flag_zero), .flag_neg(flag_neg), .flag_carry(flag_carry),
      .flag_ovf(flag_ovf), .flag_ovf_sticky(flag_ovf_sticky), .bit_true(bit_true),
      .op_fault(op_fault), .rf_rdata(rf_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk_val(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_flag(string name, logic exp, logic got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Issues one operation and looks at the answer in the cycle it stands.
   task automatic run(opcode_t o, optype_t t, logic [31:0] a, logic [15:0] b, logic [3:0] p,
                      logic [15:0] ad, logic rf, logic flt);
      @(posedge sys_clk);
      #1;
      want_op = o; want_type = t; arg_a = a; arg_b = b; arg_bit = p;
      arg_addr = ad; arg_rf = rf; go = 1'b1;
      @(posedge sys_clk);
      #1;
      go = 1'b0;
      @(negedge sys_clk);
      chk_flag("res_valid", 1'b1, res_valid);
      chk_flag("op_fault", flt, op_fault);
   endtask

   task automatic wr_word(logic [7:0] ad, logic [15:0] d);
      @(negedge sys_clk);
      rf_wr = 1'b1; rf_waddr = ad; rf_wdata = d[7:0];
      @(negedge sys_clk);
      rf_waddr = ad + 8'h01; rf_wdata = d[15:8];
      @(negedge sys_clk);
      rf_wr = 1'b0; rf_raddr = ad;
      @(negedge sys_clk);
   endtask

   task automatic t_byte;
      opcode_t ops[3] = '{OP_AND, OP_OR, OP_XOR};
      logic [7:0] ex[3] = '{8'h24, 8'hbd, 8'h99};
      run(OP_ADD, TYPE_BYTE, 32'hff, 16'h02, 4'h0, 16'h0003, 1'b0, 1'b0);
      chk_val("byte sum", 32'h01, {24'h0, result[7:0]});
      chk_flag("byte carry", 1'b1, flag_carry);
      run(OP_CMP, TYPE_BYTE, 32'h10, 16'h10, 4'h0, 16'h0003, 1'b0, 1'b0);
      chk_flag("byte equal", 1'b1, flag_zero);
      for (int i = 0; i < 3; i++) begin
         run(ops[i], TYPE_BYTE, 32'ha5, 16'h3c, 4'h0, 16'h0001, 1'b0, 1'b0);
         chk_val("byte logic", {24'h0, ex[i]}, {24'h0, result[7:0]});
      end
      run(OP_AND, TYPE_WORD, 32'hf0f0, 16'h0ff0, 4'h0, 16'h0002, 1'b0, 1'b0);
      chk_val("word and", 32'h00f0, result);
   endtask

   task automatic t_signed;
      run(OP_ADD, TYPE_SHORT, 32'h7f, 16'h01, 4'h0, 16'h0005, 1'b0, 1'b0);
      chk_val("short sum", 32'h80, {24'h0, result[7:0]});
      chk_flag("short ovf", 1'b1, flag_ovf);
      chk_flag("short neg", 1'b1, flag_neg);
      run(OP_ADD, TYPE_SHORT, 32'h7f, 16'hff, 4'h0, 16'h0005, 1'b0, 1'b0);
      chk_val("mixed sum", 32'h7e, {24'h0, result[7:0]});
      chk_flag("mixed ovf", 1'b0, flag_ovf);
      run(OP_SUB, TYPE_SHORT, 32'h80, 16'h01, 4'h0, 16'h0007, 1'b0, 1'b0);
      chk_val("short diff", 32'h7f, {24'h0, result[7:0]});
      chk_flag("sub ovf", 1'b1, flag_ovf);
      run(OP_ADD, TYPE_INT, 32'h7fff, 16'h0001, 4'h0, 16'h0008, 1'b0, 1'b0);
      chk_val("int sum", 32'h8000, {16'h0, result[15:0]});
      chk_flag("int ovf", 1'b1, flag_ovf);
      run(OP_SUB, TYPE_INT, 32'h8000, 16'h0001, 4'h0, 16'h000a, 1'b0, 1'b0);
      chk_val("int diff", 32'h7fff, {16'h0, result[15:0]});
      chk_flag("int sub ovf", 1'b1, flag_ovf);
      run(OP_ADD, TYPE_INT, 32'h0001, 16'h0001, 4'h0, 16'h0008, 1'b0, 1'b0);
      chk_flag("int no ovf", 1'b0, flag_ovf);
      chk_flag("sticky ovf", 1'b1, flag_ovf_sticky);
   endtask

   task automatic t_align;
      optype_t ty[7] = '{TYPE_WORD, TYPE_INT, TYPE_WORD, TYPE_DWORD, TYPE_DWORD, TYPE_LONG,
                         TYPE_LONG};
      opcode_t op[7] = '{OP_ADD, OP_ADD, OP_ADD, OP_SHL, OP_SHL, OP_SHL, OP_SHL};
      logic [15:0] ad[7] = '{16'h0011, 16'h0013, 16'h0012, 16'h0022, 16'h0024, 16'h0028,
                             16'h002a};
      logic rf[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      logic flt[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 7; i++) begin
         run(op[i], ty[i], 32'h1, 16'h1, 4'h0, ad[i], rf[i], flt[i]);
         if (flt[i]) chk_val("fault result", 32'h0, result);
      end
   endtask

   task automatic t_long;
      run(OP_ADD, TYPE_DWORD, 32'h1, 16'h1, 4'h0, 16'h0030, 1'b1, 1'b1);
      run(OP_SHL, TYPE_DWORD, 32'h1, 16'h4, 4'h0, 16'h0030, 1'b1, 1'b0);
      chk_val("dword shift", 32'h10, result);
      run(OP_MUL, TYPE_DWORD, 32'hffff, 16'hffff, 4'h0, 16'h0030, 1'b1, 1'b0);
      chk_val("product", 32'hfffe_0001, result);
      run(OP_DIV, TYPE_DWORD, 32'h0001_86a0, 16'h7, 4'h0, 16'h0030, 1'b1, 1'b0);
      chk_val("quotient", 32'h0005_37cd, result);
      chk_flag("div ovf", 1'b0, flag_ovf);
      run(OP_NORM, TYPE_DWORD, 32'h1, 16'h0, 4'h0, 16'h0030, 1'b1, 1'b1);
      run(OP_NORM, TYPE_LONG, 32'h1, 16'h0, 4'h0, 16'h0030, 1'b1, 1'b0);
      chk_val("normalized", 32'h8000_0000, result);
      run(OP_SHR, TYPE_LONG, 32'h8000_0000, 16'h4, 4'h0, 16'h0034, 1'b1, 1'b0);
      chk_val("long shift", 32'hf800_0000, result);
   endtask

   task automatic t_bits;
      run(OP_BTEST, TYPE_WORD, 32'h8000, 16'h0, 4'hf, 16'h0010, 1'b1, 1'b0);
      chk_flag("bit 15", 1'b1, bit_true);
      run(OP_BTEST, TYPE_WORD, 32'h8000, 16'h0, 4'h0, 16'h0010, 1'b1, 1'b0);
      chk_flag("bit 0", 1'b0, bit_true);
      run(OP_BTEST, TYPE_BYTE, 32'h0080, 16'h0, 4'h7, 16'h0011, 1'b1, 1'b0);
      chk_flag("byte bit 7", 1'b1, bit_true);
   endtask

   task automatic t_regfile;
      wr_word(8'h04, 16'h1234);
      chk_val("word read", 32'h1234, {16'h0, rf_rdata});
      wr_word(8'h00, 16'hffff);
      chk_val("zero reg", 32'h0, {16'h0, rf_rdata});
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #100us;
      num_errors++;
      finish_test();
   end

   initial begin
      arst_n = 1'b0; go = 1'b0; want_op = OP_ADD; want_type = TYPE_BYTE; arg_a = 32'h0;
      arg_b = 16'h0; arg_bit = 4'h0; arg_addr = 16'h0; arg_rf = 1'b0;
      rf_wr = 1'b0; rf_waddr = 8'h00; rf_wdata = 8'h00; rf_raddr = 8'h00;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_flag("reset res_valid", 1'b0, res_valid);
      chk_val("reset result", 32'h0, result);
      arst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      t_byte();
      t_signed();
      t_align();
      t_long();
      t_bits();
      t_regfile();
      finish_test();
   end
endmodule
`default_nettype wire
